// ### inc/lpctg_pkg.sv
package lpctg_pkg;
  // Supply monitor trip point in millivolts, analog comparator
  localparam int SUPPLY_GOOD_MV = 2300;
  localparam logic [3:0] LAD_START = 4'h0;
  localparam logic [3:0] LAD_IDLE = 4'hf;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_SHORT = 4'h5;
  localparam logic [3:0] SYNC_LONG = 4'h6;
  localparam logic [1:0] CT_IO = 2'h0;
  localparam logic [1:0] CT_DMA = 2'h2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [2:0] WAIT_IO_RD = 3'h3;
  localparam logic [2:0] WAIT_IO_WR = 3'h2;
  localparam logic [2:0] WAIT_DMA_RD = 3'h3;
  localparam logic [2:0] WAIT_DMA_WR = 3'h4;
  localparam logic [1:0] CLKRUN_HOLD = 2'h2;
  localparam logic [2:0] DRQ_BITS = 3'h4;
  localparam logic [2:0] BLK_FLOPPY = 3'h0;
  localparam logic [2:0] BLK_SER_A = 3'h1;
  localparam logic [2:0] BLK_SER_B = 3'h2;
  localparam logic [2:0] BLK_PAR = 3'h3;
  localparam logic [2:0] BLK_RUNTIME = 3'h4;
  localparam logic [2:0] BLK_CONFIG = 3'h5;
  localparam int NUM_BLK = 6;
  // Power-up base addresses
  localparam logic [15:0] BASE_FLOPPY_RST = 16'h03f0;
  localparam logic [15:0] BASE_SER_A_RST = 16'h03f8;
  localparam logic [15:0] BASE_SER_B_RST = 16'h02f8;
  localparam logic [15:0] BASE_PAR_RST = 16'h0378;
  localparam logic [15:0] BASE_RUNTIME_RST = 16'h0800;
  localparam logic [15:0] BASE_CONFIG_RST = 16'h002e;
  // Decode window lengths and offsets
  localparam logic [15:0] WIN_FLOPPY = 16'h0008;
  localparam logic [15:0] FLOPPY_HOLE = 16'h0006;
  localparam logic [15:0] WIN_SER = 16'h0008;
  localparam logic [15:0] WIN_SPP = 16'h0004;
  localparam logic [15:0] WIN_EPP = 16'h0008;
  localparam logic [15:0] ECP_EXT_OFS = 16'h0400;
  localparam logic [15:0] ECP_EXT_LEN = 16'h0003;
  localparam logic [15:0] WIN_RUNTIME = 16'h0010;
  localparam logic [15:0] WIN_CONFIG = 16'h0002;
  // Parallel mode: bit 0 wide window, bit 1 extended range
  localparam logic [1:0] PAR_SPP = 2'h0;
  localparam logic [1:0] PAR_EPP = 2'h1;
  localparam logic [1:0] PAR_ECP = 2'h2;
  localparam logic [1:0] PAR_ECP_EPP = 2'h3;
  typedef logic [22:0] lpctg_wake_vec_type;
  localparam lpctg_wake_vec_type WAKE_ANY_EDGE = 23'h1fffff;
  localparam lpctg_wake_vec_type WAKE_IDLE = 23'h600000;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_CTYPE = 11'h002,
    ST_ADDR = 11'h004,
    ST_CHAN = 11'h008,
    ST_SIZE = 11'h010,
    ST_HDATA = 11'h020,
    ST_TAR_A = 11'h040,
    ST_SYNC = 11'h080,
    ST_DDATA = 11'h100,
    ST_TAR_B = 11'h200,
    ST_SKIP = 11'h400
  } lpctg_state_type;
  typedef struct packed {
    logic valid;
    logic to_device;
    logic dma;
    logic [2:0] blk;
    logic [15:0] addr;
    logic [7:0] data;
  } lpctg_access_type;
  typedef struct packed {
    logic ring_a_n;
    logic ring_b_n;
    logic [7:0] gpio_a;
    logic [4:0] gpio_b;
    logic [7:0] gpio_c;
  } lpctg_wake_type;
endpackage

// ### hdl/lpctg_wake.sv
`timescale 1ns/10ps
module lpctg_wake (
  input wire logic i_core_clk,
  input wire logic i_trickle_rst_n,
  input wire lpctg_pkg::lpctg_wake_type i_pins,
  input wire lpctg_pkg::lpctg_wake_vec_type i_enable,
  input wire lpctg_pkg::lpctg_wake_vec_type i_clear,
  output lpctg_pkg::lpctg_wake_vec_type o_status,
  output logic o_wake_event_n,
  output logic o_wake_event_oe
);
  lpctg_pkg::lpctg_wake_vec_type meta;
  lpctg_pkg::lpctg_wake_vec_type pin_s;
  lpctg_pkg::lpctg_wake_vec_type pin_q;
  logic [1:0] warm;
  wire ev_gate = warm == 2'h3;
  wire lpctg_pkg::lpctg_wake_vec_type fall = pin_q & ~pin_s;
  wire lpctg_pkg::lpctg_wake_vec_type chg = pin_q ^ pin_s;
  // Rings wake on assertion, GPIOs on any change
  wire lpctg_pkg::lpctg_wake_vec_type wake_ev =
    (chg & lpctg_pkg::WAKE_ANY_EDGE) | (fall & ~lpctg_pkg::WAKE_ANY_EDGE);
  wire lpctg_pkg::lpctg_wake_vec_type gated_ev =
    ev_gate ? wake_ev : '0;
  // Set wins over clear
  wire lpctg_pkg::lpctg_wake_vec_type next_status =
    gated_ev | (o_status & ~i_clear);
  wire wake_hit = |(o_status & i_enable);

  // Input-only sampling, no pin drive here // R5
  always_ff @(posedge i_core_clk or negedge i_trickle_rst_n) begin
    if (!i_trickle_rst_n) begin
      meta <= lpctg_pkg::WAKE_IDLE;
      pin_s <= lpctg_pkg::WAKE_IDLE;
      pin_q <= lpctg_pkg::WAKE_IDLE;
      warm <= 2'h0;
    end else begin
      meta <= i_pins; // R4
      pin_s <= meta;
      pin_q <= pin_s;
      if (!ev_gate) begin
        warm <= warm + 2'h1;
      end
    end
  end

  // Trickle reset only, no supply gating // R2 R7
  always_ff @(posedge i_core_clk or negedge i_trickle_rst_n) begin
    if (!i_trickle_rst_n) begin
      o_status <= '0;
      o_wake_event_n <= 1'b1;
      o_wake_event_oe <= 1'b0;
    end else begin
      o_status <= next_status; // R6
      o_wake_event_n <= !wake_hit; // R3
      o_wake_event_oe <= wake_hit; // R19
    end
  end

  a_wake_pull: assert property (@(posedge i_core_clk)
    disable iff (!i_trickle_rst_n)
    wake_hit |=> o_wake_event_oe && !o_wake_event_n) // R3
    else $error("enabled wake event did not pull output");
  a_event_sticky: assert property (@(posedge i_core_clk)
    disable iff (!i_trickle_rst_n)
    gated_ev != '0 |=>
      (o_status & $past(gated_ev)) == $past(gated_ev)) // R6
    else $error("wake event lost");
  a_wake_release: assert property (@(posedge i_core_clk)
    disable iff (!i_trickle_rst_n)
    !wake_hit |=> !o_wake_event_oe) // R19
    else $error("wake output driven without event");
endmodule

// ### hdl/lpctg_top.sv
`timescale 1ns/10ps
// Summary of operation
// R1 - Synchronised supply-good low blocks all bus decoding
// R2 - Wake pins and output keep working without supply-good
// R3 - Any enabled wake event pulls the wake output low
// R4 - Wake sources: two rings, gpio groups a(8), b(5), c(8)
// R5 - Wake pins are sampled as inputs only
// R6 - Wake status sits in the trickle domain
// R7 - Trickle power-on reset initialises wake logic alone
// R8 - Every transferred register datum is one byte
// R9 - Host reaches blocks only through I/O or DMA cycles
// R10 - Block bases reset to defaults and can be rewritten
// R11 - Decode windows per block, parallel per mode, EXTENDED_PARALLEL_MODE extension
// R12 - Only single-byte I/O read/write and DMA read/write accepted
// R13 - Unsupported or unmatched cycles are ignored, bus never driven
// R14 - Host frames each cycle start and abort with frame_n
// R15 - Device sends encoded DMA requests on dma_request_n
// R16 - Powerdown floats dma_request_n and idles the interface
// R17 - Device pulls clock-run low to restart a stopped clock
// R18 - Bus reset resets the host interface logic
// R19 - Wake output is open drain, driven only on events
// R20 - Supply-good low keeps data released, DMA request high
// R21 - Frame seen active releases data lines on next clock
// R22 - Reset ignores frame, floats data, drives DMA request high
module lpctg_top (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_trickle_por_n,
  input wire logic i_supply_good,
  input wire logic [3:0] i_lad,
  output logic [3:0] o_lad,
  output logic o_lad_oe,
  input wire logic i_frame_n,
  input wire logic i_bus_powerdown_n,
  output logic o_dma_request_n,
  output logic o_dma_request_oe,
  input wire logic i_clock_run_request_n,
  output logic o_clock_run_request_n,
  output logic o_clock_run_oe,
  input wire logic i_clock_restart_req,
  input wire logic i_dma_req,
  input wire logic [2:0] i_dma_req_chan,
  input wire logic i_dma_req_act,
  output logic o_dma_busy,
  input wire logic i_dma_enable,
  input wire logic [2:0] i_dma_chan,
  input wire logic [1:0] i_par_mode,
  input wire logic i_base_wr,
  input wire logic [2:0] i_base_sel,
  input wire logic [15:0] i_base_val,
  output lpctg_pkg::lpctg_access_type o_access,
  input wire logic [7:0] i_rd_data,
  input wire lpctg_pkg::lpctg_wake_type i_wake_pins,
  input wire lpctg_pkg::lpctg_wake_vec_type i_wake_enable,
  input wire lpctg_pkg::lpctg_wake_vec_type i_wake_clear,
  output lpctg_pkg::lpctg_wake_vec_type o_wake_status,
  output logic o_wake_event_n,
  output logic o_wake_event_oe
);
  function automatic logic in_win(input logic [15:0] a,
                                  input logic [15:0] b,
                                  input logic [15:0] len);
    in_win = (a >= b) && ((a - b) < len);
  endfunction

  lpctg_pkg::lpctg_state_type state;
  lpctg_pkg::lpctg_state_type next_state;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [15:0] base [lpctg_pkg::NUM_BLK];
  logic [15:0] addr_sr;
  logic [7:0] dbuf;
  logic [2:0] blk;
  logic [1:0] nib;
  logic [1:0] next_nib;
  logic [2:0] wcnt;
  logic [2:0] next_wcnt;
  logic is_dma;
  logic dir;
  logic [3:0] drq_sr;
  logic [2:0] drq_cnt;
  logic [1:0] crun_cnt;

  // Slow pins pass two flops
  wire supply_s = sync2[2];
  wire pd_n_s = sync2[1];
  wire crun_s = sync2[0];
  wire active = supply_s && pd_n_s; // R1 R16

  wire [15:0] a_full = {addr_sr[11:0], i_lad};
  wire [15:0] par_len = i_par_mode[0] ? lpctg_pkg::WIN_EPP :
                                        lpctg_pkg::WIN_SPP;
  wire [15:0] ecp_base = base[lpctg_pkg::BLK_PAR] + lpctg_pkg::ECP_EXT_OFS;
  wire hit_fdc = in_win(a_full, base[lpctg_pkg::BLK_FLOPPY],
                        lpctg_pkg::WIN_FLOPPY) &&
    (a_full - base[lpctg_pkg::BLK_FLOPPY] != lpctg_pkg::FLOPPY_HOLE); // R11
  wire hit_sa = in_win(a_full, base[lpctg_pkg::BLK_SER_A],
                       lpctg_pkg::WIN_SER);
  wire hit_sb = in_win(a_full, base[lpctg_pkg::BLK_SER_B],
                       lpctg_pkg::WIN_SER);
  wire hit_par = in_win(a_full, base[lpctg_pkg::BLK_PAR], par_len) ||
    (i_par_mode[1] &&
     in_win(a_full, ecp_base, lpctg_pkg::ECP_EXT_LEN)); // R11
  wire hit_rt = in_win(a_full, base[lpctg_pkg::BLK_RUNTIME],
                       lpctg_pkg::WIN_RUNTIME);
  wire hit_cfg = in_win(a_full, base[lpctg_pkg::BLK_CONFIG],
                        lpctg_pkg::WIN_CONFIG);
  wire hit_any = hit_fdc | hit_sa | hit_sb | hit_par | hit_rt | hit_cfg;
  wire [2:0] hit_blk = hit_cfg ? lpctg_pkg::BLK_CONFIG :
                       hit_rt ? lpctg_pkg::BLK_RUNTIME :
                       hit_fdc ? lpctg_pkg::BLK_FLOPPY :
                       hit_sa ? lpctg_pkg::BLK_SER_A :
                       hit_sb ? lpctg_pkg::BLK_SER_B :
                       lpctg_pkg::BLK_PAR;

  // Host to device data: I/O write or DMA read
  wire host_data = is_dma ^ dir;
  wire [2:0] wait_len = is_dma ?
    (dir ? lpctg_pkg::WAIT_DMA_WR : lpctg_pkg::WAIT_DMA_RD) :
    (dir ? lpctg_pkg::WAIT_IO_WR : lpctg_pkg::WAIT_IO_RD);
  wire [3:0] sync_wait = is_dma ? lpctg_pkg::SYNC_SHORT :
                                  lpctg_pkg::SYNC_LONG;
  wire rd_take = state == lpctg_pkg::ST_SYNC && wcnt == 3'h0 && !host_data;
  wire [7:0] next_dbuf = rd_take ? i_rd_data :
    state == lpctg_pkg::ST_HDATA ?
      (nib[0] ? {i_lad, dbuf[3:0]} : {dbuf[7:4], i_lad}) : dbuf; // R8
  wire acc_fire = active && i_frame_n &&
    ((state == lpctg_pkg::ST_TAR_A && nib[0] && !host_data) ||
     (state == lpctg_pkg::ST_SYNC && wcnt == 3'h0 && host_data)); // R9
  wire next_drive = next_state == lpctg_pkg::ST_SYNC ||
    next_state == lpctg_pkg::ST_DDATA ||
    (next_state == lpctg_pkg::ST_TAR_B && !next_nib[0]);
  wire [3:0] next_lad = next_state == lpctg_pkg::ST_SYNC ?
      (next_wcnt != 3'h0 ? sync_wait : lpctg_pkg::SYNC_READY) :
    next_state == lpctg_pkg::ST_DDATA ?
      (next_nib[0] ? next_dbuf[7:4] : next_dbuf[3:0]) :
    lpctg_pkg::LAD_IDLE;
  wire dma_take = i_dma_req && drq_cnt == 3'h0 && active;
  wire crun_need = o_dma_busy || i_clock_restart_req;
  wire crun_start = crun_need && crun_s && !o_clock_run_oe;

  always_comb begin
    next_state = state;
    next_nib = nib;
    next_wcnt = wcnt;
    case (state)
      lpctg_pkg::ST_IDLE: begin
        next_state = lpctg_pkg::ST_IDLE;
      end
      lpctg_pkg::ST_CTYPE: begin
        next_nib = 2'h0;
        if (i_lad[3:2] == lpctg_pkg::CT_IO) begin
          next_state = lpctg_pkg::ST_ADDR;
        end else if (i_lad[3:2] == lpctg_pkg::CT_DMA) begin
          next_state = lpctg_pkg::ST_CHAN;
        end else begin
          next_state = lpctg_pkg::ST_SKIP; // R13
        end
      end
      lpctg_pkg::ST_ADDR: begin
        next_nib = nib + 2'h1;
        if (nib == 2'h3) begin
          next_state = !hit_any ? lpctg_pkg::ST_SKIP :
            host_data ? lpctg_pkg::ST_HDATA : lpctg_pkg::ST_TAR_A; // R13
        end
      end
      lpctg_pkg::ST_CHAN: begin
        next_state = (i_dma_enable && i_lad[2:0] == i_dma_chan) ?
          lpctg_pkg::ST_SIZE : lpctg_pkg::ST_SKIP;
      end
      lpctg_pkg::ST_SIZE: begin
        next_nib = 2'h0;
        next_state = i_lad[1:0] != lpctg_pkg::SIZE_BYTE ?
          lpctg_pkg::ST_SKIP : host_data ?
          lpctg_pkg::ST_HDATA : lpctg_pkg::ST_TAR_A; // R12
      end
      lpctg_pkg::ST_HDATA: begin
        next_nib = nib + 2'h1;
        if (nib[0]) begin
          next_state = lpctg_pkg::ST_TAR_A;
        end
      end
      lpctg_pkg::ST_TAR_A: begin
        next_nib = nib + 2'h1;
        next_wcnt = wait_len;
        if (nib[0]) begin
          next_state = lpctg_pkg::ST_SYNC;
          next_nib = 2'h0;
        end
      end
      lpctg_pkg::ST_SYNC: begin
        next_nib = 2'h0;
        if (wcnt != 3'h0) begin
          next_wcnt = wcnt - 3'h1;
        end else begin
          next_state = host_data ? lpctg_pkg::ST_TAR_B :
                                   lpctg_pkg::ST_DDATA;
        end
      end
      lpctg_pkg::ST_DDATA: begin
        next_nib = nib + 2'h1;
        if (nib[0]) begin
          next_state = lpctg_pkg::ST_TAR_B;
        end
      end
      lpctg_pkg::ST_TAR_B: begin
        next_nib = nib + 2'h1;
        if (nib[0]) begin
          next_state = lpctg_pkg::ST_IDLE;
        end
      end
      lpctg_pkg::ST_SKIP: begin
        next_state = lpctg_pkg::ST_SKIP; // R13
      end
      default: begin
        next_state = lpctg_pkg::ST_IDLE;
      end
    endcase
    if (!i_frame_n) begin
      next_state = i_lad == lpctg_pkg::LAD_START ?
        lpctg_pkg::ST_CTYPE : lpctg_pkg::ST_IDLE; // R14 R21
    end
    if (!active) begin
      next_state = lpctg_pkg::ST_IDLE; // R1
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {i_supply_good, i_bus_powerdown_n, i_clock_run_request_n};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base[lpctg_pkg::BLK_FLOPPY] <= lpctg_pkg::BASE_FLOPPY_RST; // R10
      base[lpctg_pkg::BLK_SER_A] <= lpctg_pkg::BASE_SER_A_RST;
      base[lpctg_pkg::BLK_SER_B] <= lpctg_pkg::BASE_SER_B_RST;
      base[lpctg_pkg::BLK_PAR] <= lpctg_pkg::BASE_PAR_RST;
      base[lpctg_pkg::BLK_RUNTIME] <= lpctg_pkg::BASE_RUNTIME_RST;
      base[lpctg_pkg::BLK_CONFIG] <= lpctg_pkg::BASE_CONFIG_RST;
    end else if (i_base_wr && i_base_sel <= lpctg_pkg::BLK_CONFIG) begin
      base[i_base_sel] <= i_base_val; // R10
    end
  end

  // Bus reset clears the whole host interface // R18 R22
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= lpctg_pkg::ST_IDLE;
      nib <= 2'h0;
      wcnt <= 3'h0;
      dbuf <= 8'h00;
      addr_sr <= 16'h0000;
      blk <= 3'h0;
      is_dma <= 1'b0;
      dir <= 1'b0;
      o_lad <= lpctg_pkg::LAD_IDLE;
      o_lad_oe <= 1'b0;
      o_access <= '0;
    end else begin
      state <= next_state;
      nib <= next_nib;
      wcnt <= next_wcnt;
      dbuf <= next_dbuf;
      if (state == lpctg_pkg::ST_CTYPE) begin
        is_dma <= i_lad[3];
        dir <= i_lad[1];
      end
      if (state == lpctg_pkg::ST_ADDR) begin
        addr_sr <= a_full;
      end
      if (state == lpctg_pkg::ST_CHAN) begin
        addr_sr <= {12'h000, i_lad};
      end
      if (state == lpctg_pkg::ST_ADDR && nib == 2'h3) begin
        blk <= hit_blk;
      end
      o_lad <= next_lad;
      o_lad_oe <= next_drive && active && i_frame_n; // R20 R21
      o_access <= {acc_fire, host_data, is_dma, blk, addr_sr, dbuf};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drq_sr <= 4'h0;
      drq_cnt <= 3'h0;
      o_dma_request_n <= 1'b1; // R22
      o_dma_request_oe <= 1'b1;
      o_dma_busy <= 1'b0;
    end else if (!pd_n_s || !supply_s) begin
      drq_cnt <= 3'h0;
      o_dma_request_n <= 1'b1; // R20
      o_dma_request_oe <= pd_n_s; // R16
      o_dma_busy <= 1'b0;
    end else if (dma_take) begin
      drq_sr <= {i_dma_req_act, i_dma_req_chan};
      drq_cnt <= lpctg_pkg::DRQ_BITS;
      o_dma_request_n <= 1'b0; // R15
      o_dma_request_oe <= 1'b1;
      o_dma_busy <= 1'b1;
    end else if (drq_cnt != 3'h0) begin
      drq_sr <= {1'b0, drq_sr[3:1]};
      drq_cnt <= drq_cnt - 3'h1;
      o_dma_request_n <= drq_sr[0]; // R15
      o_dma_request_oe <= 1'b1;
      o_dma_busy <= drq_cnt != 3'h1;
    end else begin
      o_dma_request_n <= 1'b1;
      o_dma_request_oe <= 1'b1;
      o_dma_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crun_cnt <= 2'h0;
      o_clock_run_oe <= 1'b0;
      o_clock_run_request_n <= 1'b0;
    end else begin
      o_clock_run_request_n <= 1'b0;
      if (crun_start) begin
        o_clock_run_oe <= 1'b1; // R17
        crun_cnt <= lpctg_pkg::CLKRUN_HOLD - 2'h1;
      end else if (crun_cnt != 2'h0) begin
        crun_cnt <= crun_cnt - 2'h1;
      end else begin
        o_clock_run_oe <= 1'b0;
      end
    end
  end

  lpctg_wake lpctg_wake_i (
    .i_core_clk(i_core_clk),
    .i_trickle_rst_n(i_trickle_por_n),
    .i_pins(i_wake_pins),
    .i_enable(i_wake_enable),
    .i_clear(i_wake_clear),
    .o_status(o_wake_status),
    .o_wake_event_n(o_wake_event_n),
    .o_wake_event_oe(o_wake_event_oe)
  );

  a_gate_no_decode: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) !supply_s |=> !o_access.valid) // R1
    else $error("access issued with supply low");
  a_gate_released: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !supply_s |=> !o_lad_oe && o_dma_request_n) // R20
    else $error("bus driven with supply low");
  a_frame_release: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) !i_frame_n |=> !o_lad_oe) // R21
    else $error("data lines still driven after frame");
  a_skip_silent: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    state == lpctg_pkg::ST_SKIP |-> !o_lad_oe) // R13
    else $error("ignored cycle drives data lines");
  a_size_reject: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    state == lpctg_pkg::ST_SIZE && i_lad[1:0] != 2'h0 &&
    i_frame_n && active |=> state == lpctg_pkg::ST_SKIP) // R12
    else $error("multi-byte cycle accepted");
  a_pd_float: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) !pd_n_s |=> !o_dma_request_oe) // R16
    else $error("dma request driven in powerdown");
  a_drq_start: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    dma_take |=> !o_dma_request_n ##4 o_dma_request_n ==
      $past(i_dma_req_act, 5)) // R15
    else $error("dma request message malformed");
  a_crun_hold: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $rose(o_clock_run_oe) |-> o_clock_run_oe[*2] ##1
      !o_clock_run_oe) // R17
    else $error("clock run pulse length wrong");
  a_floppy_hole: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    o_access.valid && !o_access.dma &&
    o_access.blk == lpctg_pkg::BLK_FLOPPY |->
      o_access.addr - base[lpctg_pkg::BLK_FLOPPY] !=
      lpctg_pkg::FLOPPY_HOLE) // R11
    else $error("floppy hole decoded");
endmodule

// ### tb/lpctg_host.sv
`timescale 1ns/10ps
module lpctg_host (
  input wire logic i_core_clk,
  input wire logic [3:0] i_lad,
  output logic o_frame_n,
  output logic [3:0] o_lad,
  output logic o_lad_oe
);
  initial begin
    o_frame_n = 1'b1;
    o_lad = 4'hf;
    o_lad_oe = 1'b0;
  end
  task automatic put(input logic f, input logic [3:0] v);
    @(negedge i_core_clk);
    o_frame_n = f;
    o_lad = v;
    o_lad_oe = 1'b1;
  endtask
  // One byte cycle; ok stays low when no ready sync shows
  task automatic cyc(input logic [3:0] ct, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic ok);
    int n;
    logic hd;
    hd = (ct == 4'h2) || (ct == 4'h8);
    q = 8'h00;
    ok = 1'b0;
    put(1'b0, 4'h0);
    put(1'b1, ct);
    if (ct[3]) begin
      put(1'b1, a[3:0]);
      put(1'b1, a[7:4]);
    end else
      for (int i = 3; i >= 0; i--) put(1'b1, a[i*4+:4]);
    if (hd) begin
      put(1'b1, d[3:0]);
      put(1'b1, d[7:4]);
    end
    put(1'b1, 4'hf);
    @(negedge i_core_clk);
    o_lad_oe = 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(negedge i_core_clk);
      ok = (i_lad === 4'h0);
    end
    if (ok && !hd) begin
      @(negedge i_core_clk);
      q[3:0] = i_lad;
      @(negedge i_core_clk);
      q[7:4] = i_lad;
    end
    repeat (3) @(negedge i_core_clk);
  endtask
endmodule

// ### tb/lpctg_top_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module lpctg_top_bench;
  logic i_core_clk = 1'b0;
  logic i_rst_n, i_trickle_por_n, i_supply_good, i_bus_powerdown_n;
  logic i_frame_n, i_clock_restart_req, i_dma_req, i_dma_req_act;
  logic i_dma_enable, i_base_wr, o_lad_oe, h_oe, o_dma_request_n;
  logic o_dma_request_oe, o_clock_run_request_n, o_clock_run_oe;
  logic o_dma_busy, o_wake_event_n, o_wake_event_oe;
  logic [2:0] i_dma_req_chan, i_dma_chan, i_base_sel;
  logic [1:0] i_par_mode;
  logic [15:0] i_base_val;
  logic [7:0] i_rd_data;
  logic [3:0] o_lad, h_lad;
  lpctg_pkg::lpctg_access_type o_access, last;
  lpctg_pkg::lpctg_wake_type i_wake_pins;
  lpctg_pkg::lpctg_wake_vec_type i_wake_enable, i_wake_clear, o_wake_status;
  int miscompares, checks_done, drv, nacc;
  wire logic [3:0] i_lad = o_lad_oe ? o_lad : (h_oe ? h_lad : 4'hf);
  wire logic i_clock_run_request_n = o_clock_run_oe ? o_clock_run_request_n
      : 1'b1;
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    if (o_lad_oe === 1'b1) drv++;
    if (o_access.valid === 1'b1) begin
      last = o_access;
      nacc++;
    end
  end
  lpctg_top lpctg_top_i (.i_core_clk, .i_rst_n, .i_trickle_por_n,
    .i_supply_good, .i_lad, .o_lad, .o_lad_oe, .i_frame_n,
    .i_bus_powerdown_n, .o_dma_request_n, .o_dma_request_oe,
    .i_clock_run_request_n, .o_clock_run_request_n, .o_clock_run_oe,
    .i_clock_restart_req, .i_dma_req, .i_dma_req_chan, .i_dma_req_act,
    .o_dma_busy, .i_dma_enable, .i_dma_chan, .i_par_mode, .i_base_wr,
    .i_base_sel, .i_base_val, .o_access, .i_rd_data, .i_wake_pins,
    .i_wake_enable, .i_wake_clear, .o_wake_status, .o_wake_event_n,
    .o_wake_event_oe);
  lpctg_host lpctg_host_i (.i_core_clk, .i_lad, .o_frame_n(i_frame_n),
    .o_lad(h_lad), .o_lad_oe(h_oe));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic acc_io(input logic [3:0] ct, input logic [15:0] a,
      input logic ok_exp, input logic [2:0] blk);
    logic [7:0] q;
    logic ok;
    int d0, n0;
    d0 = drv;
    n0 = nacc;
    lpctg_host_i.cyc(ct, a, a[7:0] ^ 8'h3c, q, ok);
    `CHK(ok, ok_exp)
    `CHK(nacc - n0, int'(ok_exp))
    if (!ok_exp) `CHK(drv, d0)
    else begin
      `CHK(last.addr, ct[3] ? {12'h000, a[3:0]} : a)
      `CHK({last.to_device, last.dma}, {ct == 4'h2 || ct == 4'h8, ct[3]})
      if (!ct[3]) `CHK(last.blk, blk)
      if (ct == 4'h2 || ct == 4'h8) `CHK(last.data, a[7:0] ^ 8'h3c)
      else `CHK(q, i_rd_data)
    end
  endtask
  task automatic t_decode;
    acc_io(4'h0, 16'h03ff, 1'b1, lpctg_pkg::BLK_SER_A);
    acc_io(4'h2, 16'h03f7, 1'b1, lpctg_pkg::BLK_FLOPPY);
    acc_io(4'h2, 16'h03f6, 1'b0, 3'h0);
    acc_io(4'h0, 16'h02f8, 1'b1, lpctg_pkg::BLK_SER_B);
    acc_io(4'h0, 16'h037b, 1'b1, lpctg_pkg::BLK_PAR);
    acc_io(4'h0, 16'h037c, 1'b0, 3'h0);
    acc_io(4'h0, 16'h080f, 1'b1, lpctg_pkg::BLK_RUNTIME);
    acc_io(4'h0, 16'h0810, 1'b0, 3'h0);
    acc_io(4'h2, 16'h002f, 1'b1, lpctg_pkg::BLK_CONFIG);
    acc_io(4'h0, 16'h0030, 1'b0, 3'h0);
    acc_io(4'h4, 16'h03f8, 1'b0, 3'h0);
    i_par_mode = lpctg_pkg::PAR_EPP;
    acc_io(4'h0, 16'h037f, 1'b1, lpctg_pkg::BLK_PAR);
    i_par_mode = lpctg_pkg::PAR_ECP;
    acc_io(4'h2, 16'h077a, 1'b1, lpctg_pkg::BLK_PAR);
    acc_io(4'h0, 16'h077b, 1'b0, 3'h0);
    acc_io(4'h8, 16'h0003, 1'b1, 3'h0);
    acc_io(4'ha, 16'h0003, 1'b1, 3'h0);
    acc_io(4'h8, 16'h0005, 1'b0, 3'h0);
    acc_io(4'h8, 16'h0013, 1'b0, 3'h0);
    @(negedge i_core_clk);
    i_base_wr = 1'b1;
    i_base_sel = lpctg_pkg::BLK_RUNTIME;
    i_base_val = 16'h0a00;
    @(negedge i_core_clk);
    i_base_wr = 1'b0;
    acc_io(4'h0, 16'h0a0f, 1'b1, lpctg_pkg::BLK_RUNTIME);
    acc_io(4'h0, 16'h080f, 1'b0, 3'h0);
    $display("test decode done");
  endtask
  task automatic t_drq;
    logic [5:0] s;
    logic seen;
    seen = 1'b0;
    @(negedge i_core_clk);
    i_dma_req = 1'b1;
    i_dma_req_chan = 3'h5;
    i_dma_req_act = 1'b1;
    @(negedge i_core_clk);
    i_dma_req = 1'b0;
    `CHK(o_dma_busy, 1'b1)
    for (int i = 0; i < 6; i++) begin
      s[i] = o_dma_request_n;
      seen |= (o_clock_run_oe === 1'b1);
      @(negedge i_core_clk);
    end
    `CHK(s, 6'h3a)
    `CHK(o_dma_busy, 1'b0)
    `CHK(seen, 1'b1)
    i_bus_powerdown_n = 1'b0;
    repeat (4) @(negedge i_core_clk);
    `CHK(o_dma_request_oe, 1'b0)
    acc_io(4'h0, 16'h03f8, 1'b0, 3'h0);
    i_bus_powerdown_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    `CHK({o_dma_request_oe, o_dma_request_n}, 2'h3)
    seen = 1'b0;
    i_clock_restart_req = 1'b1;
    repeat (4) begin
      @(negedge i_core_clk);
      seen |= (o_clock_run_oe === 1'b1);
    end
    i_clock_restart_req = 1'b0;
    `CHK(seen, 1'b1)
    `CHK(o_clock_run_request_n, 1'b0)
    $display("test dma request done");
  endtask
  task automatic t_wake;
    i_supply_good = 1'b0;
    repeat (3) @(negedge i_core_clk);
    acc_io(4'h0, 16'h03f8, 1'b0, 3'h0);
    `CHK(o_dma_request_n, 1'b1)
    i_wake_enable = 23'h000100;
    i_wake_pins.gpio_b[0] = 1'b1;
    repeat (8) @(negedge i_core_clk);
    `CHK({o_wake_event_n, o_wake_event_oe}, 2'h1)
    i_rst_n = 1'b0;
    i_wake_pins.ring_b_n = 1'b0;
    repeat (8) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    `CHK(o_wake_status, 23'h200100)
    i_wake_clear = 23'h000100;
    @(negedge i_core_clk);
    i_wake_clear = 23'h000000;
    `CHK(o_wake_status, 23'h200000)
    i_trickle_por_n = 1'b0;
    @(negedge i_core_clk);
    `CHK(o_wake_status, 23'h000000)
    i_trickle_por_n = 1'b1;
    i_supply_good = 1'b1;
    repeat (4) @(negedge i_core_clk);
    `CHK(o_wake_event_n, 1'b1)
    $display("test wake done");
  endtask
  initial begin
    #100us;
    miscompares++;
    report_and_stop;
  end
  initial begin
    i_rst_n = 1'b0;
    i_trickle_por_n = 1'b0;
    i_supply_good = 1'b1;
    i_bus_powerdown_n = 1'b1;
    i_clock_restart_req = 1'b0;
    i_dma_req = 1'b0;
    i_dma_req_chan = 3'h0;
    i_dma_req_act = 1'b0;
    i_dma_enable = 1'b1;
    i_dma_chan = 3'h3;
    i_par_mode = lpctg_pkg::PAR_SPP;
    i_base_wr = 1'b0;
    i_base_sel = 3'h0;
    i_base_val = 16'h0000;
    i_rd_data = 8'h5a;
    i_wake_pins = lpctg_pkg::WAKE_IDLE;
    i_wake_enable = 23'h000000;
    i_wake_clear = 23'h000000;
    repeat (10) @(negedge i_core_clk);
    `CHK({o_lad_oe, o_dma_request_oe, o_dma_request_n}, 3'h3)
    `CHK(o_access.valid, 1'b0)
    i_rst_n = 1'b1;
    i_trickle_por_n = 1'b1;
    repeat (3) @(negedge i_core_clk);
    t_decode;
    t_drq;
    t_wake;
    report_and_stop;
  end
endmodule
